/* core/arm_register_name_mapper.v */
// architected-to-logical register mapper with core build parameters
// assumes decode drives one architected number per cycle, same clock
// Overview of operation
// [RQ1] supervisor globals 1-7 go to shadow slots 9-15; others to 0-7
// [RQ2] only one shadow set; nested traps reuse it
// [RQ3] trap pc, npc, state, cause map to 68..71 plus four times depth
// [RQ4] fp compare flags 32-35 to 16-19; int flags 36, 38 to 20
// [RQ5] user state registers 40,42-46 map to 24,26-30
// [RQ6] window registers 65-70 to 45-50; privileged 60-64 to 40-44
// [RQ7] translation registers 73-82 to 53-62; 83-86 unused
// [RQ8] decode converts recorded architected numbers using window and state
// [RQ9] with class-window limit, stall decode when target window is full
// [RQ10] active list size configurable, default 64
// [RQ11] fetch, decode, graduate 4 per cycle; fetch queue 8
// [RQ12] exception flush rate configurable, default 4 per cycle
// [RQ13] predictor type selectable, 512 entries; stack and shadow maps 4
// [RQ14] integer latencies: shift 1, multiply 3, divide 9, other 1
// [RQ15] fp latencies: move 1, convert 4, divide 10, sqrt 10, other 3
// [RQ16] repeat: integer and fp move/other 1, convert 2, divide/sqrt 6
// [RQ17] two alus, two fpus, one address unit, one load/store unit
// [RQ18] each translation buffer typed, 128 entries, associativity 1
// [RQ19] processor state bit 3 selects normal or alternate globals
// [RQ20] version register: windows 7:0, trap levels 15:8, version 31:24
// [RQ21] all configuration values are overridable parameters with defaults
`include "arm_regs.vh"
module arm_register_name_mapper #(
  parameter NUM_WINDOWS     = `ARM_DEF_WINDOWS,
  parameter NUM_TRAPS       = `ARM_DEF_TRAPS,
  parameter VERSION         = 1,
  parameter STALL_ON_FULL   = 1,
  parameter MAX_ALU_OPS     = `ARM_DEF_CLASSWIN,
  parameter MAX_FPU_OPS     = `ARM_DEF_CLASSWIN,
  parameter MAX_MEM_OPS     = `ARM_DEF_CLASSWIN,
  parameter ACTIVE_LIST     = `ARM_DEF_ACTIVE,
  parameter FETCH_QUEUE     = `ARM_DEF_FETCHQ,
  parameter FETCH_RATE      = `ARM_DEF_RATE,
  parameter DECODE_RATE     = `ARM_DEF_RATE,
  parameter GRAD_RATE       = `ARM_DEF_RATE,
  parameter FLUSH_RATE      = `ARM_DEF_RATE,
  parameter [1:0] BP_TYPE   = `ARM_BP_TWOBIT,
  parameter BP_SIZE         = `ARM_DEF_BPB,
  parameter RAS_SIZE        = `ARM_DEF_RAS,
  parameter SHADOW_MAPPERS  = `ARM_DEF_SHADOWMAP,
  parameter LAT_SHIFT       = 1,
  parameter LAT_MUL         = 3,
  parameter LAT_DIV         = 9,
  parameter LAT_INT         = 1,
  parameter LAT_FMOV        = 1,
  parameter LAT_FCONV       = 4,
  parameter LAT_FDIV        = 10,
  parameter LAT_FSQRT       = 10,
  parameter LAT_FLT         = 3,
  parameter REP_SHIFT       = 1,
  parameter REP_MUL         = 1,
  parameter REP_DIV         = 1,
  parameter REP_INT         = 1,
  parameter REP_FMOV        = 1,
  parameter REP_FCONV       = 2,
  parameter REP_FDIV        = 6,
  parameter REP_FSQRT       = 6,
  parameter REP_FLT         = 1,
  parameter NUM_ALUS        = 2,
  parameter NUM_FPUS        = 2,
  parameter NUM_ADDRS       = 1,
  parameter NUM_MEMS        = 1,
  parameter [1:0] ITLB_TYPE = `ARM_TLB_DIRECT,
  parameter ITLB_SIZE       = `ARM_DEF_TLBSIZE,
  parameter ITLB_ASSOC      = `ARM_DEF_TLBASSOC,
  parameter [1:0] DTLB_TYPE = `ARM_TLB_DIRECT,
  parameter DTLB_SIZE       = `ARM_DEF_TLBSIZE,
  parameter DTLB_ASSOC      = `ARM_DEF_TLBASSOC
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire        archValid,
  input  wire [6:0]  archReg,
  input  wire [7:0]  procState,
  input  wire [7:0]  curWindow,
  input  wire [7:0]  trapDepth,
  input  wire [1:0]  instClass,
  input  wire [7:0]  aluOpsInFlight,
  input  wire [7:0]  fpuOpsInFlight,
  input  wire [7:0]  memOpsInFlight,
  output wire        decodeStall,
  output reg         logValid,
  output reg  [9:0]  logReg,
  output reg         logUnused,
  output wire [31:0] versionWord,
  output wire [15:0] activeListSize,
  output wire [7:0]  fetchQueueSize,
  output wire [7:0]  fetchRate,
  output wire [7:0]  decodeRate,
  output wire [7:0]  gradRate,
  output wire [7:0]  flushRate,
  output wire [1:0]  bpType,
  output wire [15:0] bpSize,
  output wire [7:0]  rasSize,
  output wire [7:0]  shadowMappers,
  output wire [39:0] intLatency,
  output wire [39:0] fpLatency,
  output wire [39:0] intRepeat,
  output wire [39:0] fpRepeat,
  output wire [31:0] unitCounts,
  output wire [1:0]  itlbType,
  output wire [15:0] itlbSize,
  output wire [7:0]  itlbAssoc,
  output wire [1:0]  dtlbType,
  output wire [15:0] dtlbSize,
  output wire [7:0]  dtlbAssoc
);
  localparam [1:0] CLS_ALU = 2'h0;
  localparam [1:0] CLS_FPU = 2'h1;
  localparam [1:0] CLS_MEM = 2'h2;
  localparam [9:0] WIN_BASE = `ARM_LOG_TRAP_BASE + NUM_TRAPS * 4;
  // configuration values sized to their ports
  localparam [7:0]  WIN_CNT  = NUM_WINDOWS;
  localparam [7:0]  TRAP_CNT = NUM_TRAPS;
  localparam [7:0]  VER_NUM  = VERSION;
  localparam [15:0] ACT_SZ   = ACTIVE_LIST;
  localparam [7:0]  FQ_SZ    = FETCH_QUEUE;
  localparam [7:0]  FET_R    = FETCH_RATE;
  localparam [7:0]  DEC_R    = DECODE_RATE;
  localparam [7:0]  GRD_R    = GRAD_RATE;
  localparam [7:0]  FLS_R    = FLUSH_RATE;
  localparam [15:0] BP_SZ    = BP_SIZE;
  localparam [7:0]  RAS_SZ   = RAS_SIZE;
  localparam [7:0]  SHM_CNT  = SHADOW_MAPPERS;
  localparam [7:0]  L_SH     = LAT_SHIFT;
  localparam [7:0]  L_MUL    = LAT_MUL;
  localparam [7:0]  L_DIV    = LAT_DIV;
  localparam [7:0]  L_INT    = LAT_INT;
  localparam [7:0]  L_FMOV   = LAT_FMOV;
  localparam [7:0]  L_FCONV  = LAT_FCONV;
  localparam [7:0]  L_FDIV   = LAT_FDIV;
  localparam [7:0]  L_FSQRT  = LAT_FSQRT;
  localparam [7:0]  L_FLT    = LAT_FLT;
  localparam [7:0]  R_SH     = REP_SHIFT;
  localparam [7:0]  R_MUL    = REP_MUL;
  localparam [7:0]  R_DIV    = REP_DIV;
  localparam [7:0]  R_INT    = REP_INT;
  localparam [7:0]  R_FMOV   = REP_FMOV;
  localparam [7:0]  R_FCONV  = REP_FCONV;
  localparam [7:0]  R_FDIV   = REP_FDIV;
  localparam [7:0]  R_FSQRT  = REP_FSQRT;
  localparam [7:0]  R_FLT    = REP_FLT;
  localparam [7:0]  U_ALU    = NUM_ALUS;
  localparam [7:0]  U_FPU    = NUM_FPUS;
  localparam [7:0]  U_ADDR   = NUM_ADDRS;
  localparam [7:0]  U_MEM    = NUM_MEMS;
  localparam [15:0] ITLB_SZ  = ITLB_SIZE;
  localparam [7:0]  ITLB_AS  = ITLB_ASSOC;
  localparam [15:0] DTLB_SZ  = DTLB_SIZE;
  localparam [7:0]  DTLB_AS  = DTLB_ASSOC;

  wire       [7:0] winIdx;

  reg  [9:0] next_logReg;
  reg        next_unused;
  reg        classFull;
  wire       altGlobals;

  // build-time configuration exposed as constants
  assign activeListSize = ACT_SZ;                                 // [RQ10] [RQ21]
  assign fetchQueueSize = FQ_SZ;                                  // [RQ11]
  assign fetchRate      = FET_R;                                  // [RQ11]
  assign decodeRate     = DEC_R;                                  // [RQ11]
  assign gradRate       = GRD_R;                                  // [RQ11]
  assign flushRate      = FLS_R;                                  // [RQ12]
  assign bpType         = BP_TYPE;                                // [RQ13]
  assign bpSize         = BP_SZ;                                  // [RQ13]
  assign rasSize        = RAS_SZ;                                 // [RQ13]
  assign shadowMappers  = SHM_CNT;                                // [RQ13]
  // order per byte: other, divide, multiply, shift (plus one spare)
  assign intLatency = {8'h00, L_INT, L_DIV, L_MUL, L_SH};        // [RQ14]
  // order: other, sqrt, divide, convert, move
  assign fpLatency  = {L_FLT, L_FSQRT, L_FDIV, L_FCONV, L_FMOV};  // [RQ15]
  assign intRepeat  = {8'h00, R_INT, R_DIV, R_MUL, R_SH};        // [RQ16]
  assign fpRepeat   = {R_FLT, R_FSQRT, R_FDIV, R_FCONV, R_FMOV};  // [RQ16]
  // order: load/store, address, fpu, alu
  assign unitCounts = {U_MEM, U_ADDR, U_FPU, U_ALU};             // [RQ17]
  assign itlbType   = ITLB_TYPE;                                  // [RQ18]
  assign itlbSize   = ITLB_SZ;                                    // [RQ18]
  assign itlbAssoc  = ITLB_AS;                                    // [RQ18]
  assign dtlbType   = DTLB_TYPE;                                  // [RQ18]
  assign dtlbSize   = DTLB_SZ;                                    // [RQ18]
  assign dtlbAssoc  = DTLB_AS;                                    // [RQ18]

  // window index within the built window count
  assign winIdx = curWindow % WIN_CNT;                            // [RQ8]

  // single shadow set, selected by state bit; no nesting depth involved
  assign altGlobals = procState[`ARM_PSTATE_AG_BIT];              // [RQ19] [RQ2]

  // issue-window class limit
  always @* begin
    classFull = 1'b0;
    case (instClass)
      CLS_ALU: classFull = aluOpsInFlight >= MAX_ALU_OPS;
      CLS_FPU: classFull = fpuOpsInFlight >= MAX_FPU_OPS;
      CLS_MEM: classFull = memOpsInFlight >= MAX_MEM_OPS;
      default: classFull = 1'b0;
    endcase
  end
  assign decodeStall = (STALL_ON_FULL != 0) && archValid && classFull; // [RQ9]

  // architected to logical translation
  always @* begin
    next_logReg = 10'h000;
    next_unused = 1'b0;
    if (archReg < 7'h08) begin
      if (altGlobals && archReg != 7'h00)
        next_logReg = `ARM_SHADOW_BASE + {3'h0, archReg};        // [RQ1]
      else
        next_logReg = {3'h0, archReg};                            // [RQ1]
    end else if (archReg < 7'h20) begin
      // windowed: 16 new per window, ins overlap next window's outs
      next_logReg = WIN_BASE + {winIdx[5:0], 4'h0}
                    + {3'h0, archReg} - 10'h008;                  // [RQ8]
    end else if (archReg <= `ARM_ARCH_FCC3) begin
      next_logReg = `ARM_LOG_FCC0 + {3'h0, archReg - `ARM_ARCH_FCC0}; // [RQ4]
    end else if (archReg == `ARM_ARCH_ICC || archReg == `ARM_ARCH_XCC) begin
      next_logReg = `ARM_LOG_ICC;                                 // [RQ4]
    end else if (archReg >= `ARM_ARCH_USR_LO && archReg <= `ARM_ARCH_USR_HI) begin
      next_logReg = {3'h0, archReg} - `ARM_USR_OFS;               // [RQ5]
    end else if (archReg == `ARM_ARCH_MEMBAR) begin
      next_logReg = `ARM_LOG_MEMBAR;
    end else if (archReg >= `ARM_ARCH_TPC && archReg <= `ARM_ARCH_TT) begin
      next_logReg = `ARM_LOG_TRAP_BASE + {3'h0, archReg - `ARM_ARCH_TPC}
                    + {trapDepth, 2'b00};                         // [RQ3]
    end else if (archReg >= `ARM_ARCH_PRIV_LO && archReg <= `ARM_ARCH_WIN_HI) begin
      next_logReg = {3'h0, archReg} - `ARM_PRIV_OFS;              // [RQ6]
    end else if (archReg == `ARM_ARCH_FQ || archReg == `ARM_ARCH_TLBCTX) begin
      next_logReg = {3'h0, archReg} - `ARM_PRIV_OFS;
    end else if (archReg >= `ARM_ARCH_TLB_LO && archReg <= `ARM_ARCH_TLB_HI) begin
      next_logReg = {3'h0, archReg} - `ARM_PRIV_OFS;              // [RQ7]
    end else if (archReg >= `ARM_ARCH_UNU_LO && archReg <= `ARM_ARCH_UNU_HI) begin
      next_logReg = {3'h0, archReg} - `ARM_PRIV_OFS;
      next_unused = 1'b1;                                         // [RQ7]
    end else if (archReg == `ARM_ARCH_VER) begin
      next_logReg = `ARM_LOG_VER;
    end else begin
      next_unused = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      logValid  <= 1'b0;
      logReg    <= 10'h000;
      logUnused <= 1'b0;
    end else begin
      logValid <= archValid && !decodeStall;                      // [RQ8]
      if (archValid && !decodeStall) begin
        logReg    <= next_logReg;
        logUnused <= next_unused;
      end
    end
  end

  arm_version_reg #(
    .NUM_WINDOWS (WIN_CNT),
    .NUM_TRAPS   (TRAP_CNT),
    .VERSION     (VER_NUM)
  ) uVersion (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .versionWord (versionWord)
  );
endmodule

/* core/arm_regs.vh */
// register map constants: architected and logical slot numbers, core defaults
// assumes inclusion by the mapper and its version-register module
`ifndef ARM_REGS_VH
`define ARM_REGS_VH
`define ARM_ARCH_W        7
`define ARM_LOG_W         10
`define ARM_SHADOW_BASE   10'h008
`define ARM_ARCH_FCC0     7'h20
`define ARM_ARCH_FCC3     7'h23
`define ARM_LOG_FCC0      10'h010
`define ARM_ARCH_ICC      7'h24
`define ARM_ARCH_XCC      7'h26
`define ARM_LOG_ICC       10'h014
`define ARM_ARCH_USR_LO   7'h28
`define ARM_ARCH_USR_HI   7'h2E
`define ARM_USR_OFS       10'h010
`define ARM_ARCH_MEMBAR   7'h37
`define ARM_LOG_MEMBAR    10'h027
`define ARM_ARCH_TPC      7'h38
`define ARM_ARCH_TT       7'h3B
`define ARM_LOG_TRAP_BASE 10'h044
`define ARM_ARCH_PRIV_LO  7'h3C
`define ARM_ARCH_WIN_HI   7'h46
`define ARM_PRIV_OFS      10'h014
`define ARM_ARCH_FQ       7'h47
`define ARM_ARCH_TLBCTX   7'h48
`define ARM_LOG_TLBCTX    10'h034
`define ARM_ARCH_TLB_LO   7'h49
`define ARM_ARCH_TLB_HI   7'h52
`define ARM_ARCH_UNU_LO   7'h53
`define ARM_ARCH_UNU_HI   7'h56
`define ARM_ARCH_VER      7'h57
`define ARM_LOG_VER       10'h043
`define ARM_PSTATE_AG_BIT 3
`define ARM_PSTATE_PRIV   0
`define ARM_VER_WIN_LSB   0
`define ARM_VER_TL_LSB    8
`define ARM_VER_NUM_LSB   24
`define ARM_DEF_WINDOWS   8
`define ARM_DEF_TRAPS     4
`define ARM_DEF_ACTIVE    64
`define ARM_DEF_CLASSWIN  16
`define ARM_DEF_FETCHQ    8
`define ARM_DEF_RATE      4
`define ARM_DEF_BPB       512
`define ARM_DEF_RAS       4
`define ARM_DEF_SHADOWMAP 4
`define ARM_BP_TWOBIT     2'h0
`define ARM_BP_AGREE      2'h1
`define ARM_BP_STATIC     2'h2
`define ARM_TLB_DIRECT    2'h0
`define ARM_TLB_SETASSOC  2'h1
`define ARM_TLB_FULLASSOC 2'h2
`define ARM_DEF_TLBSIZE   128
`define ARM_DEF_TLBASSOC  1
`endif

/* core/arm_version_reg.v */
// read-only version word, registered
// assumes a single clock and asynchronous active-low reset
`include "arm_regs.vh"
module arm_version_reg #(
  parameter [7:0] NUM_WINDOWS = `ARM_DEF_WINDOWS,
  parameter [7:0] NUM_TRAPS   = `ARM_DEF_TRAPS,
  parameter [7:0] VERSION     = 8'h01
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  output reg  [31:0] versionWord
);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      versionWord <= 32'h0000_0000;
    end else begin
      versionWord <= {VERSION, 8'h00, NUM_TRAPS, NUM_WINDOWS}; // [RQ20]
    end
  end
endmodule

/* tb/arm_issue_model.sv */
// issue-window occupancy model for the decode side
// assumes one clock, rst_n async active low
module arm_issue_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [2:0] bump,
  input  wire logic       clear,
  output logic      [7:0] aluOpsInFlight,
  output logic      [7:0] fpuOpsInFlight,
  output logic      [7:0] memOpsInFlight
);
  timeunit 1ns;
  timeprecision 1ns;
  // per-class occupancy, one entry per bump cycle
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aluOpsInFlight <= 8'h00;
      fpuOpsInFlight <= 8'h00;
      memOpsInFlight <= 8'h00;
    end else if (clear) begin
      aluOpsInFlight <= 8'h00;
      fpuOpsInFlight <= 8'h00;
      memOpsInFlight <= 8'h00;
    end else begin
      aluOpsInFlight <= aluOpsInFlight + {7'h00, bump[0]};
      fpuOpsInFlight <= fpuOpsInFlight + {7'h00, bump[1]};
      memOpsInFlight <= memOpsInFlight + {7'h00, bump[2]};
    end
  end
endmodule

/* tb/arm_map_chk.sv */
// port assertions for the register name mapper
// assumes one clock, rst_n async active low
module arm_map_chk #(
  parameter MAX_ALU_OPS = 16
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       archValid,
  input wire logic [6:0] archReg,
  input wire logic [7:0] procState,
  input wire logic [7:0] trapDepth,
  input wire logic [1:0] instClass,
  input wire logic [7:0] aluOpsInFlight,
  input wire logic       decodeStall,
  input wire logic       logValid,
  input wire logic [9:0] logReg,
  input wire logic       logUnused
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire take = archValid && !decodeStall;
  alu_stall_a: assert property (archValid && instClass == 2'h0 && aluOpsInFlight >= MAX_ALU_OPS |-> decodeStall)
    else $error("no stall on full window");
  none_stall_a: assert property (instClass == 2'h3 |-> !decodeStall)
    else $error("stall on class none");
  answer_pulse_a: assert property (take |=> logValid)
    else $error("no answer after request");
  refused_req_a: assert property (!take |=> !logValid)
    else $error("answer without taken request");
  shadow_glob_a: assert property (take && procState[3] && archReg inside {[7'h01:7'h07]}
    |=> logReg == 10'h008 + $past(archReg))
    else $error("shadow global slot wrong");
  normal_glob_a: assert property (take && !procState[3] && archReg < 7'h08 |=> logReg == $past(archReg))
    else $error("normal global slot wrong");
  trap_stack_a: assert property (take && archReg inside {[7'h38:7'h3B]}
    |=> logReg == 10'h044 + {$past(trapDepth), 2'h0} + $past(archReg) - 10'h038)
    else $error("trap stack slot wrong");
  state_map_a: assert property (take && archReg inside {[7'h20:7'h23], 7'h28, [7'h2A:7'h2E]}
    |=> logReg == $past(archReg) - 10'h010)
    else $error("state slot wrong");
  priv_map_a: assert property (take && archReg inside {[7'h3C:7'h46], [7'h49:7'h52]}
    |=> logReg == $past(archReg) - 10'h014 && !logUnused)
    else $error("privileged slot wrong");
  unused_flag_a: assert property (take && archReg inside {[7'h53:7'h56]} |=> logUnused)
    else $error("unused not flagged");
endmodule
bind arm_register_name_mapper arm_map_chk #(.MAX_ALU_OPS(MAX_ALU_OPS)) i_chk (.*);

/* tb/arch_register_map_core_params_bench.sv */
// testbench for the register name mapper
// assumes mapper, issue model and checker compiled first
module arch_register_map_core_params_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'h0, rst_n = 1'h0, archValid = 1'h0, clear = 1'h0;
  logic [6:0]  archReg = 7'h00;
  logic [7:0]  procState = 8'h00, curWindow = 8'h00, trapDepth = 8'h00;
  logic [1:0]  instClass = 2'h3;
  logic [2:0]  bump = 3'h0;
  wire  [7:0]  aluOpsInFlight, fpuOpsInFlight, memOpsInFlight, fetchQueueSize, fetchRate;
  wire  [7:0]  decodeRate, gradRate, flushRate, rasSize, shadowMappers, itlbAssoc, dtlbAssoc;
  wire         decodeStall, logValid, logUnused;
  wire  [9:0]  logReg;
  wire  [31:0] versionWord, unitCounts;
  wire  [39:0] intLatency, fpLatency, intRepeat, fpRepeat;
  wire  [15:0] activeListSize, bpSize, itlbSize, dtlbSize;
  wire  [1:0]  bpType, itlbType, dtlbType;
  int          fails = 0, total_checks = 0;
  logic [6:0]  aList[$] = '{7'h20, 7'h23, 7'h24, 7'h26, 7'h28, 7'h2E, 7'h3C, 7'h41, 7'h46, 7'h49, 7'h52, 7'h37,
                           7'h47, 7'h48, 7'h57};
  logic [9:0]  eList[$] = '{10'h010, 10'h013, 10'h014, 10'h014, 10'h018, 10'h01E, 10'h028, 10'h02D, 10'h032,
                           10'h035, 10'h03E, 10'h027, 10'h033, 10'h034, 10'h043};
  arm_register_name_mapper i_dut (.*);
  arm_issue_model i_issue (.*);
  initial forever #50 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one request, judged one cycle later; valid stays up for back-to-back
  task automatic map(input logic [6:0] a, input logic [7:0] ps, td, input logic [9:0] e, input logic u);
    archReg = a;
    procState = ps;
    trapDepth = td;
    archValid = 1'h1;
    @(posedge clk_sys);
    #1;
    chk("logValid", logValid, 1'h1);
    if (!u) chk("logReg", logReg, e);
    chk("logUnused", logUnused, u);
  endtask
  task automatic t_map;
    for (int i = 0; i < 8; i++) begin
      map(7'(i), 8'h08, 8'h00, (i == 0) ? 10'h000 : 10'h008 + 10'(i), 1'h0);
      map(7'(i), 8'h09, 8'h03, (i == 0) ? 10'h000 : 10'h008 + 10'(i), 1'h0);
      map(7'(i), 8'h00, 8'h00, 10'(i), 1'h0);
    end
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 4; k++) begin
        map(7'h38 + 7'(k), 8'h01, 8'(t), 10'h044 + 10'(t * 4 + k), 1'h0);
      end
    end
    foreach (aList[i]) map(aList[i], 8'h00, 8'h00, eList[i], 1'h0);
    for (int k = 0; k < 4; k++) map(7'h53 + 7'(k), 8'h00, 8'h00, 10'h000, 1'h1);
    map(7'h30, 8'h00, 8'h00, 10'h000, 1'h1);
    curWindow = 8'h01;
    map(7'h08, 8'h00, 8'h00, 10'h064, 1'h0);
  endtask
  task automatic t_stall;
    instClass = 2'h0;
    bump = 3'h7;
    repeat (16) @(posedge clk_sys);
    #1;
    bump = 3'h0;
    for (int c = 0; c < 4; c++) begin
      instClass = 2'(c);
      #1;
      chk("decodeStall", decodeStall, c != 3);
      @(posedge clk_sys);
      #1;
      chk("logValid", logValid, c == 3);
    end
    instClass = 2'h0;
    clear = 1'h1;
    @(posedge clk_sys);
    #1;
    clear = 1'h0;
    chk("decodeStall", decodeStall, 1'h0);
    archValid = 1'h0;
  endtask
  task automatic t_cfg;
    chk("active", activeListSize, 16'h0040);
    chk("fetch", {fetchQueueSize, fetchRate, decodeRate, gradRate}, 32'h08040404);
    chk("flush", flushRate, 8'h04);
    chk("predictor", {bpType, bpSize, rasSize, shadowMappers}, 34'h002000404);
    chk("intLat", intLatency, 40'h0001090301);
    chk("fpLat", fpLatency, 40'h030A0A0401);
    chk("intRep", intRepeat, 40'h0001010101);
    chk("fpRep", fpRepeat, 40'h0106060201);
    chk("units", unitCounts, 32'h01010202);
    chk("tlb", {itlbType, itlbSize, itlbAssoc, dtlbType, dtlbSize, dtlbAssoc},
        {2'h0, 16'h0080, 8'h01, 2'h0, 16'h0080, 8'h01});
    chk("version", versionWord, 32'h01000408);
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    chk("logValid", logValid, 1'h0);
    chk("version", versionWord, 32'h00000000);
    rst_n = 1'h1;
    @(posedge clk_sys);
    #1;
    t_cfg();
    t_map();
    t_stall();
    wrap_up();
  end
endmodule
